/* rtl/act_pkg.sv */
// act_pkg: register map, field positions and reset values of the converter trigger block
// assumes: 8-bit register port, one clock domain, synchronous active-low reset
package act_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_A_PINS = 8'h05;
    localparam logic [7:0] OFS_PORT_E_PINS = 8'h09;
    localparam logic [7:0] OFS_CORE_INT_CTRL = 8'h0b;
    localparam logic [7:0] OFS_PERIPH_FLAGS_ONE = 8'h0c;
    localparam logic [7:0] OFS_PERIPH_FLAGS_TWO = 8'h0d;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h1e;
    localparam logic [7:0] OFS_CONV_CTRL_ZERO = 8'h1f;
    localparam logic [7:0] OFS_PORT_A_DIR = 8'h85;
    localparam logic [7:0] OFS_PORT_E_DIR = 8'h89;
    localparam logic [7:0] OFS_PERIPH_EN_ONE = 8'h8c;
    localparam logic [7:0] OFS_PERIPH_EN_TWO = 8'h8d;
    localparam logic [7:0] OFS_CONV_CTRL_ONE = 8'h9f;
    localparam logic [7:0] OFS_EVT_STATUS = 8'ha0;
    localparam logic [7:0] OFS_EVT_MASK = 8'ha1;

    // ------------------------------------------------------------------
    // reset values and implemented-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIR = 8'hff;
    localparam logic [2:0] RST_PORT_E_DIR = 3'h7;
    localparam logic [7:0] MASK_FLAGS_TWO = 8'heb;
    localparam logic [7:0] MASK_PORT_E = 8'h0f;
    localparam logic [7:0] MASK_EVT = 8'h07;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_CONV_FLAG = 6;
    localparam int BIT_E_LINE_THREE_DIR = 3;
    localparam int EVT_TRIG_TAKEN = 0;
    localparam int EVT_TRIG_IGNORED = 1;
    localparam int EVT_CONV_DONE = 2;
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;

    // converter control zero layout
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] chan_lo;
        logic go_done;
        logic chan_hi;
        logic converter_on;
    } act_ctl0_s;

    // result delivered by the analog converter
    typedef struct packed {
        logic done;
        logic [7:0] result;
    } act_conv_s;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } act_state_e;

endpackage : act_pkg

/* rtl/act_trigger.sv */
// act_trigger: compare-trigger start logic of the converter and its register file
// assumes: compare unit delivers its special event as a one-cycle pulse on mclk_i;
// the analog converter reports completion with a one-cycle done pulse and result byte
//
// Behaviour
// - start request accepted only with mode field 1011 and converter on
// - accepted trigger sets go/done, starting conversion like a software write
// - every trigger clears the companion timer counter to zero
// - converter off: trigger ignored, go/done unchanged, timer still cleared
// - unimplemented bits read zero; writes to them have no effect
// - port E line three input only; its direction bit reads one always
// - conversion done clears go/done and loads result high byte
// - reset disables converter, aborts conversion, restores register reset values
//
// Added by the designer: the strobed register port.
module act_trigger #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [3:0] compare_mode_select_i,
    input wire logic special_event_i,
    output logic timer_clear_o,
    output logic conv_start_o,
    output logic conv_abort_o,
    output logic converter_on_o,
    output logic [3:0] conv_channel_o,
    input wire act_pkg::act_conv_s conv_i,
    input wire logic [7:0] port_a_pins_i,
    output logic [7:0] port_a_out_o,
    output logic [7:0] port_a_dir_o,
    input wire logic [3:0] port_e_pins_i,
    output logic [2:0] port_e_out_o,
    output logic [2:0] port_e_dir_o,
    output logic irq_o
);

    // a narrower bus could not reach the upper register bank
    if (ADDR_W < 8) begin : g_addr_w_check
        $error("act_trigger: ADDR_W must be at least 8");
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr, input logic [7:0] set);
        w1c = (cur & ~clr) | set;
    endfunction : w1c

    // one select per register, shared by write decode and read mux
    wire logic sel_ctl0 = hit(addr_i, act_pkg::OFS_CONV_CTRL_ZERO);
    wire logic sel_ctl1 = hit(addr_i, act_pkg::OFS_CONV_CTRL_ONE);
    wire logic sel_res = hit(addr_i, act_pkg::OFS_RESULT_HIGH);
    wire logic sel_pa = hit(addr_i, act_pkg::OFS_PORT_A_PINS);
    wire logic sel_pa_dir = hit(addr_i, act_pkg::OFS_PORT_A_DIR);
    wire logic sel_pe = hit(addr_i, act_pkg::OFS_PORT_E_PINS);
    wire logic sel_pe_dir = hit(addr_i, act_pkg::OFS_PORT_E_DIR);
    wire logic sel_intc = hit(addr_i, act_pkg::OFS_CORE_INT_CTRL);
    wire logic sel_fl1 = hit(addr_i, act_pkg::OFS_PERIPH_FLAGS_ONE);
    wire logic sel_fl2 = hit(addr_i, act_pkg::OFS_PERIPH_FLAGS_TWO);
    wire logic sel_en1 = hit(addr_i, act_pkg::OFS_PERIPH_EN_ONE);
    wire logic sel_en2 = hit(addr_i, act_pkg::OFS_PERIPH_EN_TWO);
    wire logic sel_evt = hit(addr_i, act_pkg::OFS_EVT_STATUS);
    wire logic sel_msk = hit(addr_i, act_pkg::OFS_EVT_MASK);

    wire logic wr_ctl0 = wr_i & sel_ctl0;
    wire logic wr_ctl1 = wr_i & sel_ctl1;
    wire logic wr_res = wr_i & sel_res;
    wire logic wr_pa = wr_i & sel_pa;
    wire logic wr_pa_dir = wr_i & sel_pa_dir;
    wire logic wr_pe = wr_i & sel_pe;
    wire logic wr_pe_dir = wr_i & sel_pe_dir;
    wire logic wr_intc = wr_i & sel_intc;
    wire logic wr_fl1 = wr_i & sel_fl1;
    wire logic wr_fl2 = wr_i & sel_fl2;
    wire logic wr_en1 = wr_i & sel_en1;
    wire logic wr_en2 = wr_i & sel_en2;
    wire logic wr_evt = wr_i & sel_evt;
    wire logic wr_msk = wr_i & sel_msk;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    act_pkg::act_ctl0_s ctl0_q;
    act_pkg::act_ctl0_s ctl0_d;
    act_pkg::act_state_e state_q;
    act_pkg::act_state_e state_d;
    logic [7:0] ctl1_q;
    logic [7:0] result_q;
    logic [7:0] pa_out_q;
    logic [7:0] pa_dir_q;
    logic [2:0] pe_out_q;
    logic [2:0] pe_dir_q;
    logic [7:0] intc_q;
    logic [7:0] fl1_q;
    logic [7:0] fl2_q;
    logic [7:0] en1_q;
    logic [7:0] en2_q;
    logic [7:0] evt_q;
    logic [7:0] msk_q;
    logic [7:0] rdata_q;
    logic start_q;
    logic abort_q;

    // ------------------------------------------------------------------
    // trigger qualification
    // ------------------------------------------------------------------
    wire logic mode_sel = (compare_mode_select_i == act_pkg::MODE_SPECIAL_EVENT);
    wire logic trig_taken = special_event_i & mode_sel & ctl0_q.converter_on;
    wire logic trig_ignored = special_event_i & mode_sel & ~ctl0_q.converter_on;
    // a done pulse outside a conversion (late, after reset or abort) is dropped
    wire logic conv_done = conv_i.done & (state_q == act_pkg::ST_BUSY);
    act_pkg::act_ctl0_s wr_ctl0_val;
    assign wr_ctl0_val = act_pkg::act_ctl0_s'(wdata_i);

    // timer reset is independent of the converter-on bit
    assign timer_clear_o = special_event_i & mode_sel;

    // ------------------------------------------------------------------
    // go/done flag and conversion sequencing
    // ------------------------------------------------------------------
    always_comb begin
        ctl0_d = ctl0_q;
        state_d = state_q;
        if (wr_ctl0) begin
            ctl0_d = wr_ctl0_val;
        end
        if (conv_done) begin
            ctl0_d.go_done = 1'b0;
        end
        if (trig_taken) begin
            ctl0_d.go_done = 1'b1;
        end
        case (state_q)
            act_pkg::ST_IDLE: begin
                if (ctl0_d.go_done && ctl0_d.converter_on) begin
                    state_d = act_pkg::ST_BUSY;
                end
            end
            act_pkg::ST_BUSY: begin
                if (conv_done || !ctl0_d.go_done || !ctl0_d.converter_on) begin
                    state_d = act_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = act_pkg::ST_IDLE;
            end
        endcase
    end

    // a start issued by the trigger follows the same path as a software start
    wire logic start_d = (state_q == act_pkg::ST_IDLE) & (state_d == act_pkg::ST_BUSY);
    // software clearing go or converter-on mid-conversion reports an abort
    wire logic abort_d = (state_q == act_pkg::ST_BUSY) & (state_d == act_pkg::ST_IDLE) & ~conv_done;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ctl0_q <= act_pkg::act_ctl0_s'(act_pkg::RST_ZERO);
            state_q <= act_pkg::ST_IDLE;
            start_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            ctl0_q <= ctl0_d;
            state_q <= state_d;
            start_q <= start_d;
            abort_q <= abort_d;
        end
    end

    // result byte: converter load wins over a software write in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            result_q <= act_pkg::RST_ZERO;
        end else if (conv_done) begin
            result_q <= conv_i.result;
        end else if (wr_res) begin
            result_q <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // plain control registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ctl1_q <= act_pkg::RST_ZERO;
            pa_out_q <= act_pkg::RST_ZERO;
            pa_dir_q <= act_pkg::RST_PORT_A_DIR;
            pe_out_q <= 3'h0;
            pe_dir_q <= act_pkg::RST_PORT_E_DIR;
            intc_q <= act_pkg::RST_ZERO;
            en1_q <= act_pkg::RST_ZERO;
            en2_q <= act_pkg::RST_ZERO;
            msk_q <= act_pkg::RST_ZERO;
        end else begin
            if (wr_ctl1) begin
                ctl1_q <= wdata_i;
            end
            if (wr_pa) begin
                pa_out_q <= wdata_i;
            end
            if (wr_pa_dir) begin
                pa_dir_q <= wdata_i;
            end
            if (wr_pe) begin
                pe_out_q <= wdata_i[2:0];
            end
            if (wr_pe_dir) begin
                pe_dir_q <= wdata_i[2:0];
            end
            if (wr_intc) begin
                intc_q <= wdata_i;
            end
            if (wr_en1) begin
                en1_q <= wdata_i;
            end
            if (wr_en2) begin
                en2_q <= wdata_i & act_pkg::MASK_FLAGS_TWO;
            end
            if (wr_msk) begin
                msk_q <= wdata_i & act_pkg::MASK_EVT;
            end
        end
    end

    // ------------------------------------------------------------------
    // flags and events: hardware set wins over a clear in the same cycle
    // ------------------------------------------------------------------
    wire logic [7:0] evt_set = {5'h00, conv_done, trig_ignored, trig_taken};
    wire logic [7:0] fl1_set = {1'b0, conv_done, 6'h00};

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            fl1_q <= act_pkg::RST_ZERO;
            fl2_q <= act_pkg::RST_ZERO;
            evt_q <= act_pkg::RST_ZERO;
        end else begin
            fl1_q <= (wr_fl1 ? wdata_i : fl1_q) | fl1_set;
            if (wr_fl2) begin
                fl2_q <= wdata_i & act_pkg::MASK_FLAGS_TWO;
            end
            evt_q <= w1c(evt_q, wr_evt ? wdata_i : 8'h00, evt_set) & act_pkg::MASK_EVT;
        end
    end

    // ------------------------------------------------------------------
    // read mux, data one cycle after the strobe
    // ------------------------------------------------------------------
    logic [7:0] rmux;
    always_comb begin
        rmux = 8'h00;
        if (sel_ctl0) rmux = ctl0_q;
        if (sel_ctl1) rmux = ctl1_q;
        if (sel_res) rmux = result_q;
        if (sel_pa) rmux = port_a_pins_i;
        if (sel_pa_dir) rmux = pa_dir_q;
        if (sel_pe) rmux = {4'h0, port_e_pins_i} & act_pkg::MASK_PORT_E;
        if (sel_pe_dir) rmux = {4'h0, 1'b1, pe_dir_q};
        if (sel_intc) rmux = intc_q;
        if (sel_fl1) rmux = fl1_q;
        if (sel_fl2) rmux = fl2_q;
        if (sel_en1) rmux = en1_q;
        if (sel_en2) rmux = en2_q;
        if (sel_evt) rmux = evt_q;
        if (sel_msk) rmux = msk_q;
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_i ? rmux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o = rdata_q;
    assign conv_start_o = start_q;
    assign conv_abort_o = abort_q;
    assign converter_on_o = ctl0_q.converter_on;
    assign conv_channel_o = {ctl0_q.chan_hi, ctl0_q.chan_lo};
    assign port_a_out_o = pa_out_q;
    assign port_a_dir_o = pa_dir_q;
    // line three has no driver at all: it is an input-only pin
    assign port_e_out_o = pe_out_q;
    assign port_e_dir_o = pe_dir_q;
    assign irq_o = |(evt_q & msk_q);

endmodule : act_trigger

/* test/act_trigger_props.sv */
// act_trigger_props: port-level checks of the converter trigger block
// assumes: bound to act_trigger, one clock, synchronous active-low reset
module act_trigger_props #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [3:0] compare_mode_select_i,
    input wire logic special_event_i,
    input wire logic timer_clear_o,
    input wire logic conv_start_o,
    input wire logic conv_abort_o,
    input wire logic converter_on_o,
    input wire act_pkg::act_conv_s conv_i,
    input wire logic [7:0] port_a_dir_o,
    input wire logic [2:0] port_e_dir_o,
    input wire logic irq_o
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    logic busy_q;
    logic busy_d;
    logic trig;
    // conservative busy: stays up through the abort cycle
    assign busy_d = conv_start_o | (busy_q & ~conv_i.done & ~conv_abort_o);
    assign trig = special_event_i && compare_mode_select_i == 4'hb;
    always_ff @(posedge mclk_i) begin
        busy_q <= nrst_i ? busy_d : 1'b0;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    property p_tclr; timer_clear_o == trig; endproperty
    a_tclr: assert property (p_tclr) else $error("timer clear wrong");
    property p_on; trig && converter_on_o && !busy_q && !conv_start_o && !wr_i |=> conv_start_o; endproperty
    a_on: assert property (p_on) else $error("trigger did not start");
    property p_off; trig && !converter_on_o && !wr_i |=> !conv_start_o; endproperty
    a_off: assert property (p_off) else $error("start while off");
    property p_pulse; conv_start_o |=> !conv_start_o; endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_rd0; !rd_i |=> rdata_o == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("read data without read");
    property p_edir; rd_i && addr_i == 8'h89 |=> rdata_o[7:3] == 5'h01; endproperty
    a_edir: assert property (p_edir) else $error("line three direction");
    property p_mask2; rd_i && (addr_i == 8'h0d || addr_i == 8'h8d) |=> (rdata_o & 8'h14) == 8'h00; endproperty
    a_mask2: assert property (p_mask2) else $error("unimplemented bit set");
    property p_rst; $rose(nrst_i) |-> !irq_o && !converter_on_o && port_a_dir_o == 8'hff && port_e_dir_o == 3'h7;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    c_on: cover property (trig && converter_on_o);
    c_off: cover property (trig && !converter_on_o);
    c_done: cover property (busy_q && conv_i.done);
endmodule : act_trigger_props

bind act_trigger act_trigger_props #(.ADDR_W(ADDR_W)) u_props (.mclk_i, .nrst_i, .addr_i, .wr_i, .rd_i,
    .rdata_o, .compare_mode_select_i, .special_event_i, .timer_clear_o, .conv_start_o, .conv_abort_o,
    .converter_on_o, .conv_i, .port_a_dir_o, .port_e_dir_o, .irq_o);

/* test/act_partner.sv */
// act_partner: compare unit with its sixteen-bit timer, plus a converter stand-in
// assumes: shares clock and reset with the block; bench drives enable and compare value
module act_partner #(
    parameter int DLY = 12
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [15:0] cmp_i,
    input wire logic timer_clear_i,
    input wire logic conv_start_i,
    input wire logic conv_abort_i,
    input wire logic [7:0] result_i,
    output logic special_event_o,
    output logic [15:0] timer_o,
    output act_pkg::act_conv_s conv_o
);
    logic [15:0] tmr_q;
    // analog side ignores device reset: a late done must be dropped by the block
    logic [7:0] cnt_q = 8'h00;
    assign special_event_o = en_i && tmr_q == cmp_i;
    assign timer_o = tmr_q;
    wire logic done_w = cnt_q == 8'h01;
    // junk on the result byte outside the done pulse
    assign conv_o = {done_w, done_w ? result_i : ~result_i};
    always_ff @(posedge mclk_i) begin
        tmr_q <= (!nrst_i || timer_clear_i) ? 16'h0000 : tmr_q + 16'h0001;
    end
    always_ff @(posedge mclk_i) begin
        if (conv_abort_i) begin
            cnt_q <= 8'h00;
        end else if (conv_start_i) begin
            cnt_q <= 8'(DLY);
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : act_partner

/* test/tb_act_trigger.sv */
// tb_act_trigger: self-checking bench of the converter trigger block
// assumes: package, block, partner model and bound checker compiled before it
module tb_act_trigger;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, sev, tclr, start, abort, on, irq;
    logic nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, en = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, res = 8'h00, pa_pins = 8'h00, rdata_o, pa_out, pa_dir, a, d;
    logic [3:0] mode = 4'h0, pe_pins = 4'h0, chan;
    logic [2:0] pe_out, pe_dir;
    logic [15:0] cmp = 16'h0000, tmr;
    act_pkg::act_conv_s conv;
    logic [7:0] ra[12] = '{8'h1f, 8'h9f, 8'h85, 8'h89, 8'h0c, 8'h0d, 8'h8c, 8'h8d, 8'ha0, 8'ha1, 8'h1e, 8'h40};
    logic [7:0] rv[12] = '{8'h00, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wa[8] = '{8'h0d, 8'h8d, 8'ha1, 8'h89, 8'h9f, 8'h85, 8'h0b, 8'h8c};
    integer seed = 36;
    int n_errors = 0;
    int total_checks = 0;
    int i, k, hits;
    act_trigger dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .compare_mode_select_i(mode), .special_event_i(sev),
        .timer_clear_o(tclr), .conv_start_o(start), .conv_abort_o(abort), .converter_on_o(on),
        .conv_channel_o(chan), .conv_i(conv), .port_a_pins_i(pa_pins), .port_a_out_o(pa_out),
        .port_a_dir_o(pa_dir), .port_e_pins_i(pe_pins), .port_e_out_o(pe_out), .port_e_dir_o(pe_dir), .irq_o(irq));
    act_partner u_far (.mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(en), .cmp_i(cmp), .timer_clear_i(tclr),
        .conv_start_i(start), .conv_abort_i(abort), .result_i(res), .special_event_o(sev), .timer_o(tmr),
        .conv_o(conv));
    // ----------------------------------------
    // clock, watchdog, tasks
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge mclk_i);
        addr_i <= ad;
        wdata_i <= dt;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr_reg
    task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rchk
    // readback after a write: unimplemented bits drop, line three direction reads one
    function automatic logic [7:0] rb(input logic [7:0] ad, input logic [7:0] dt);
        case (ad)
            8'h0d, 8'h8d: rb = dt & 8'heb;
            8'ha1: rb = dt & 8'h07;
            8'h89: rb = {4'h0, 1'b1, dt[2:0]};
            default: rb = dt;
        endcase
    endfunction : rb
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        pa_pins = 8'($random(seed));
        pe_pins = 4'($random(seed));
        repeat (6) @(posedge mclk_i);
        nrst_i <= 1'b1;
        foreach (ra[j]) rchk(ra[j], rv[j]);
        rchk(8'h05, pa_pins);
        rchk(8'h09, {4'h0, pe_pins});
        $display("test reset_values finished");
        for (i = 0; i < 24; i++) begin
            a = wa[3'($random(seed))];
            d = 8'($random(seed));
            if (a == 8'h8c) d[7] = 1'b0;
            wr_reg(a, d);
            rchk(a, rb(a, d));
        end
        wr_reg(8'h89, 8'h00);
        rchk(8'h89, 8'h08);
        chk({5'h00, pe_dir}, 8'h00);
        wr_reg(8'h05, 8'h5a);
        wr_reg(8'h85, 8'h3c);
        wr_reg(8'h09, 8'hfe);
        #1;
        chk(pa_out, 8'h5a);
        chk(pa_dir, 8'h3c);
        chk({5'h00, pe_out}, 8'h06);
        $display("test register_access finished");
        wr_reg(8'h1f, 8'h00);
        for (int m = 0; m < 16; m++) begin
            wr_reg(8'ha0, 8'hff);
            mode <= 4'(m);
            cmp <= tmr + 16'd4;
            en <= 1'b1;
            hits = 0;
            for (k = 0; k < 8; k++) begin
                tick();
                if (tclr) begin
                    hits++;
                    tick();
                    chk(tmr[15:8] | tmr[7:0], 8'h00);
                end
            end
            en <= 1'b0;
            chk(8'(hits), {7'h00, m == 11});
            rchk(8'ha0, m == 11 ? 8'h02 : 8'h00);
            rchk(8'h1f, 8'h00);
        end
        $display("test modes_while_off finished");
        wr_reg(8'ha0, 8'hff);
        wr_reg(8'ha1, 8'h04);
        wr_reg(8'h1f, 8'h0b);
        tick();
        chk({4'h0, chan}, 8'h09);
        res <= 8'($random(seed));
        mode <= 4'hb;
        cmp <= tmr + 16'd30;
        en <= 1'b1;
        for (i = 0; i < 60 && start !== 1'b1; i++) tick();
        en <= 1'b0;
        chk(start, 1'b1);
        rchk(8'h1f, 8'h0f);
        for (i = 0; i < 60 && irq !== 1'b1; i++) tick();
        chk(irq, 1'b1);
        rchk(8'h1f, 8'h0b);
        rchk(8'h1e, res);
        rchk(8'h0c, 8'h40);
        rchk(8'ha0, 8'h05);
        wr_reg(8'ha0, 8'h04);
        tick();
        chk(irq, 1'b0);
        rchk(8'ha0, 8'h01);
        $display("test triggered_conversion finished");
        wr_reg(8'h1f, 8'h05);
        #1;
        chk(start, 1'b1);
        wr_reg(8'h1f, 8'h01);
        #1;
        chk(abort, 1'b1);
        wr_reg(8'h1f, 8'h05);
        #1;
        chk(start, 1'b1);
        nrst_i <= 1'b0;
        repeat (2) tick();
        nrst_i <= 1'b1;
        chk(on, 1'b0);
        chk(abort, 1'b0);
        rchk(8'h1f, 8'h00);
        rchk(8'h1e, 8'h00);
        repeat (20) tick();
        rchk(8'ha0, 8'h00);
        $display("test reset_abort finished");
        give_verdict();
    end
endmodule : tb_act_trigger
